// file: core/cbmi_map.vh
// register map, field positions and reset values of the mask/interrupt block
`ifndef CBMI_MAP_VH
`define CBMI_MAP_VH
`define CBMI_OFF_MASK_LOW   12'h000
`define CBMI_OFF_MASK_EXT   12'h004
`define CBMI_OFF_IRQ_EN     12'h008
`define CBMI_OFF_IRQ_PEND   12'h00C
`define CBMI_OFF_IRQ_CLR    12'h010
`define CBMI_OFF_CODE_EN    12'h014
`define CBMI_OFF_STATUS     12'h018
`define CBMI_OFF_CONFIG     12'h01C
`define CBMI_RST_WORD       16'h0000
`define CBMI_ERR_BIT        15
`define CBMI_LOW_ID_HI      15
`define CBMI_LOW_ID_LO      5
`define CBMI_LOW_RTR        4
`define CBMI_LOW_IDE        3
`define CBMI_EXT_EXTENDED_REMOTE_MASK       0
`define CBMI_STAT_RQ        4
`endif

// file: core/cbmi_prio_enc.v
// priority encoder producing the status interrupt source code
`timescale 1ns/1ps
module cbmi_prio_enc (
  input  wire [15:0] pend,
  input  wire [15:0] code_en,
  output reg         rq,
  output reg  [3:0]  code
);
  reg [15:0] act;
  integer    i;
  always @* begin
    act  = pend & code_en; // [R17] [R18]
    rq   = 1'b0;
    code = 4'h0;
    // lowest buffer number wins; error outranks all buffers
    for (i = 14; i >= 0; i = i - 1) begin
      if (act[i]) begin
        rq   = 1'b1;
        code = i[3:0] + 4'h1; // [R19]
      end
    end
    if (act[15]) begin
      rq   = 1'b1;
      code = 4'h0; // [R19]
    end
  end
endmodule // cbmi_prio_enc

// file: core/cbmi_top.v
// basic mask acceptance for buffer 14 and interrupt bookkeeping, apb slave
// How it works
// R1 - basic mask acts only on acceptance filtering for buffer 14
// R2 - mask bit 0: incoming bit must equal buffer identifier bit
// R3 - mask bit 1: bit ignored; on accept buffer id bit takes received bit
// R4 - extended frames use mask 28:0, ide, srr via rtr mask, rtr via extended_remote_mask
// R5 - standard frames use mask 28:18 for id 10:0, rtr and ide only
// R6 - low word: mask 28:18 at 15:5, rtr 4, ide 3, mask 17:15 at 2:0
// R7 - enable register: bit 15 error, bits 14:0 buffer enables
// R8 - error enable 1 lets error state changes request an interrupt
// R9 - buffer enable 0 stops that buffer being an interrupt source
// R10 - buffer pending bit set after each good transfer through it
// R11 - error pending set on error counter status change
// R12 - software clears pending only through the clear register
// R13 - writing 1 to clear register clears pending; 0 leaves it
// R14 - clear bit 15 clears error pending, bits 14:0 buffer pendings
// R15 - software uses plain full writes to the clear register
// R16 - code enable register selects sources feeding the interrupt code
// R17 - error code enable gates error pending into the code
// R18 - buffer code enable gates buffer pending into the code
// R19 - code: none rq0/0, error rq1/0, buffer n rq1/n+1
// R20 - error type: 0 every bus error, 1 node state change only
// R21 - irq high while any pending bit has its enable set
// R22 - reset clears mask, enable, pending and code enable
`timescale 1ns/1ps
`include "cbmi_map.vh"
module cbmi_top #(
  parameter NBUF = 15
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rx_check,
  input  wire        rx_ext,
  input  wire [28:0] rx_id,
  input  wire        rx_rtr,
  input  wire        rx_srr,
  input  wire [28:0] buf_id,
  input  wire        buf_rtr,
  input  wire        buf_ide,
  input  wire        buf_srr,
  output reg         buf14_match,
  output reg  [28:0] buf14_new_id,
  output reg         buf14_new_rtr,
  output reg         buf14_new_srr,
  input  wire [14:0] buf_done,
  input  wire        bus_error,
  input  wire        node_state_change,
  output reg         cpu_irq,
  output reg         irq_rq,
  output reg  [3:0]  interrupt_source_code
);
  reg  [15:0] basic_mask_low_word;
  reg  [15:0] basic_mask_extended_word;
  reg  [15:0] can_interrupt_enable;
  reg  [15:0] can_interrupt_pending;
  reg  [15:0] can_interrupt_code_enable;
  reg         error_interrupt_type;
  reg  [15:0] next_pending;
  reg  [15:0] clr_mask;
  reg  [15:0] set_mask;
  reg  [31:0] rd_word;
  reg         rd_ok;
  wire [28:0] basic_mask_id_bits;
  wire        rtr_mask;
  wire        ide_mask;
  wire        extended_remote_mask;
  wire        enc_rq;
  wire [3:0]  enc_code;
  wire        acc;
  wire        wr_acc;
  wire        err_evt;
  reg  [28:0] id_care;
  reg         hit;

  assign acc    = psel & penable;
  assign wr_acc = acc & pwrite;

  // reassemble the 29-bit id mask from its two halves
  assign basic_mask_id_bits = {basic_mask_low_word[15:5],
                               basic_mask_low_word[2:0],
                               basic_mask_extended_word[15:1]}; // [R6]
  assign rtr_mask = basic_mask_low_word[`CBMI_LOW_RTR];         // [R6]
  assign ide_mask = basic_mask_low_word[`CBMI_LOW_IDE];         // [R6]
  assign extended_remote_mask =
    basic_mask_extended_word[`CBMI_EXT_EXTENDED_REMOTE_MASK];

  // acceptance compare for buffer 14
  always @* begin
    id_care = ~basic_mask_id_bits;
    hit     = 1'b0;
    if (rx_ext) begin
      hit = (((rx_id ^ buf_id) & id_care) == 29'h0) // [R2] [R4]
            && (ide_mask | buf_ide)
            && (rtr_mask | (rx_srr == buf_srr))
            && (extended_remote_mask | (rx_rtr == buf_rtr));
    end else begin
      // standard id 10:0 sits against mask 28:18 [R5]
      hit = (((rx_id[10:0] ^ buf_id[28:18]) & id_care[28:18]) == 11'h0)
            && (ide_mask | ~buf_ide)
            && (rtr_mask | (rx_rtr == buf_rtr));
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf14_match   <= 1'b0;
      buf14_new_id  <= 29'h0;
      buf14_new_rtr <= 1'b0;
      buf14_new_srr <= 1'b0;
    end else begin
      buf14_match <= rx_check & hit; // [R1]
      if (rx_ext) begin
        // masked bits take the received value [R3]
        buf14_new_id  <= (buf_id & id_care) |
                         (rx_id & basic_mask_id_bits);
        buf14_new_srr <= rtr_mask ? rx_srr : buf_srr;
        buf14_new_rtr <= extended_remote_mask ? rx_rtr : buf_rtr;
      end else begin
        buf14_new_id  <= {(buf_id[28:18] & id_care[28:18]) |
                          (rx_id[10:0] & basic_mask_id_bits[28:18]),
                          buf_id[17:0]}; // [R3]
        buf14_new_srr <= buf_srr;
        buf14_new_rtr <= rtr_mask ? rx_rtr : buf_rtr;
      end
    end
  end

  assign err_evt = error_interrupt_type ? node_state_change
                                        : bus_error; // [R20] [R11]

  // pending flags: a set in the same cycle as its clear wins
  always @* begin
    clr_mask = 16'h0000;
    if (wr_acc && paddr == `CBMI_OFF_IRQ_CLR)
      clr_mask = pwdata[15:0]; // [R13] [R14]
    set_mask = {err_evt, buf_done[NBUF-1:0]}; // [R10] [R11]
    next_pending = (can_interrupt_pending & ~clr_mask) | set_mask;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      basic_mask_low_word       <= `CBMI_RST_WORD; // [R22]
      basic_mask_extended_word  <= `CBMI_RST_WORD;
      can_interrupt_enable      <= `CBMI_RST_WORD;
      can_interrupt_pending     <= `CBMI_RST_WORD;
      can_interrupt_code_enable <= `CBMI_RST_WORD;
      error_interrupt_type      <= 1'b0;
    end else begin
      can_interrupt_pending <= next_pending;
      if (wr_acc) begin
        case (paddr)
          `CBMI_OFF_MASK_LOW: begin
            basic_mask_low_word <= pwdata[15:0];
          end
          `CBMI_OFF_MASK_EXT: begin
            basic_mask_extended_word <= pwdata[15:0];
          end
          `CBMI_OFF_IRQ_EN: begin
            can_interrupt_enable <= pwdata[15:0]; // [R7]
          end
          `CBMI_OFF_CODE_EN: begin
            can_interrupt_code_enable <= pwdata[15:0]; // [R16]
          end
          `CBMI_OFF_CONFIG: begin
            error_interrupt_type <= pwdata[0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  cbmi_prio_enc u_enc (
    .pend    (can_interrupt_pending),
    .code_en (can_interrupt_code_enable),
    .rq      (enc_rq),
    .code    (enc_code)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_irq               <= 1'b0;
      irq_rq                <= 1'b0;
      interrupt_source_code <= 4'h0;
    end else begin
      // [R8] [R9] [R21]
      cpu_irq <= |(can_interrupt_pending & can_interrupt_enable);
      irq_rq                <= enc_rq;   // [R19]
      interrupt_source_code <= enc_code; // [R19]
    end
  end

  // read mux; clear register reads zero, pending is read-only [R12]
  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (paddr)
      `CBMI_OFF_MASK_LOW:  rd_word[15:0] = basic_mask_low_word;
      `CBMI_OFF_MASK_EXT:  rd_word[15:0] = basic_mask_extended_word;
      `CBMI_OFF_IRQ_EN:    rd_word[15:0] = can_interrupt_enable;
      `CBMI_OFF_IRQ_PEND:  rd_word[15:0] = can_interrupt_pending;
      `CBMI_OFF_IRQ_CLR:   rd_word[15:0] = 16'h0000; // [R15]
      `CBMI_OFF_CODE_EN:   rd_word[15:0] = can_interrupt_code_enable;
      `CBMI_OFF_STATUS:    rd_word[4:0]  = {irq_rq, interrupt_source_code};
      `CBMI_OFF_CONFIG:    rd_word[0]    = error_interrupt_type;
      default:             rd_ok         = 1'b0;
    endcase
  end

  // zero-wait apb: pready pulses in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_ok;
      if (psel & ~penable & ~pwrite)
        prdata <= rd_word;
    end
  end
endmodule // cbmi_top

// file: dv/cbmi_chk.sv
// port assertions for the mask and interrupt block
`timescale 1ns/1ps
`include "cbmi_map.vh"
module cbmi_chk (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        rx_check,
  input logic [14:0] buf_done,
  input logic        bus_error,
  input logic        node_state_change,
  input logic        buf14_match,
  input logic        cpu_irq,
  input logic        irq_rq,
  input logic [3:0]  interrupt_source_code
);
  logic [1:0] cyc;
  wire        ev = |buf_done || bus_error || node_state_change;
  wire        wr = psel && penable && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cyc <= 2'h0;
    else if (cyc != 2'h3)
      cyc <= cyc + 2'h1;
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  a_ready_next: assert property (s_setup |=> pready) else $error("no ready");
  a_ready_once: assert property (pready |=> !pready) else $error("long ready");
  a_clear_reads: assert property (
    s_setup ##0 (!pwrite && paddr == `CBMI_OFF_IRQ_CLR) |=> prdata == 32'h0)
    else $error("clear register read not zero");
  a_match_cause: assert property (
    buf14_match |-> $past(rx_check)) else $error("match without check");
  a_idle_code: assert property (
    !irq_rq |-> interrupt_source_code == 4'h0) else $error("code without rq");
  a_irq_rise: assert property (
    $rose(cpu_irq) |-> $past(ev || wr) || $past(ev || wr, 2))
    else $error("irq rose without cause");
  a_irq_fall: assert property (
    $fell(cpu_irq) |-> $past(wr) || $past(wr, 2)) else $error("irq fell");
  a_reset_quiet: assert property (
    cyc < 2'h2 |-> !cpu_irq && !irq_rq) else $error("irq after reset");
endmodule // cbmi_chk
bind cbmi_top cbmi_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .rx_check, .buf_done, .bus_error,
  .node_state_change, .buf14_match, .cpu_irq, .irq_rq, .interrupt_source_code);

// file: dv/can_basic_mask_and_interrupts_tb_top.sv
// self-checking bench for the mask and interrupt block
`timescale 1ns/1ps
`include "cbmi_map.vh"
module can_basic_mask_and_interrupts_tb_top;
  localparam logic [11:0] ml = `CBMI_OFF_MASK_LOW, mx = `CBMI_OFF_MASK_EXT,
    en = `CBMI_OFF_IRQ_EN, pn = `CBMI_OFF_IRQ_PEND, cl = `CBMI_OFF_IRQ_CLR,
    ce = `CBMI_OFF_CODE_EN, st = `CBMI_OFF_STATUS, cf = `CBMI_OFF_CONFIG;
  logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic        rx_check = '0, rx_ext = '0, rx_rtr = '0, rx_srr = '0, e;
  logic        buf_rtr = '0, buf_ide = '0, buf_srr = '0, bus_error = '0;
  logic        node_state_change = '0, pready, pslverr, buf14_match;
  logic        buf14_new_rtr, buf14_new_srr, cpu_irq, irq_rq;
  logic [3:0]  interrupt_source_code;
  logic [11:0] paddr = '0;
  logic [14:0] buf_done = '0;
  logic [28:0] rx_id = '0, buf_id = '0, buf14_new_id;
  logic [31:0] pwdata = '0, prdata, q;
  int          miscompares = 0, total_checks = 0;
  always #10 pclk = ~pclk;
  cbmi_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_check, .rx_ext, .rx_id, .rx_rtr, .rx_srr,
    .buf_id, .buf_rtr, .buf_ide, .buf_srr, .buf14_match, .buf14_new_id,
    .buf14_new_rtr, .buf14_new_srr, .buf_done, .bus_error, .node_state_change,
    .cpu_irq, .irq_rq, .interrupt_source_code);
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int i;
    i = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++i < 20);
    if (i >= 20) begin
      miscompares++;
      print_verdict;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] x, string n);
    apb(1'b0, a, 32'h0);
    chk(n, x, q);
  endtask
  task automatic pulse(logic [14:0] b, logic be, logic ns);
    buf_done <= b;
    bus_error <= be;
    node_state_change <= ns;
    @(posedge pclk);
    buf_done <= 15'h0;
    bus_error <= 1'b0;
    node_state_change <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic frame(logic x, logic i, logic [28:0] id, logic m, string n);
    rx_ext <= x;
    buf_ide <= i;
    rx_id <= id;
    rx_check <= 1'b1;
    @(posedge pclk);
    rx_check <= 1'b0;
    @(posedge pclk);
    chk(n, m, buf14_match);
  endtask
  task automatic t_regs;
    logic [11:0] rw[4] = '{ml, mx, en, ce};
    for (int a = 0; a < 8; a++) rd(12'(a * 4), 32'h0, "reset");
    rd(12'h020, 32'h0, "unmapped");
    chk("slverr", 32'h1, e);
    foreach (rw[k]) apb(1'b1, rw[k], 32'hFFFFFFFF);
    foreach (rw[k]) rd(rw[k], 32'hFFFF, "rw");
    apb(1'b1, pn, 32'hFFFF);
    rd(pn, 32'h0, "pend ro");
    rd(cl, 32'h0, "clear wo");
    $display("regs done");
  endtask
  task automatic t_buf;
    for (int n = 0; n < 15; n++) begin
      pulse(15'h1 << n, 1'b0, 1'b0);
      chk("irq", 32'h1, cpu_irq);
      rd(pn, 32'h1 << n, "pend");
      rd(st, 32'h11 + n, "code");
      apb(1'b1, cl, 32'h7FFF ^ (32'h1 << n));
      rd(pn, 32'h1 << n, "clr 0");
      apb(1'b1, cl, 32'h1 << n);
      rd(pn, 32'h0, "clr 1");
    end
    $display("buf done");
  endtask
  task automatic t_err;
    pulse(15'h4000, 1'b1, 1'b0);
    rd(pn, 32'hC000, "err pend");
    rd(st, 32'h10, "err first");
    apb(1'b1, ce, 32'h7FFF);
    rd(st, 32'h1F, "err code off");
    apb(1'b1, en, 32'h0);
    // the irq flop takes the new enable one edge after the write commits
    @(posedge pclk);
    chk("irq off", 32'h0, cpu_irq);
    apb(1'b1, cl, 32'hC000);
    apb(1'b1, cf, 32'h1);
    pulse(15'h0, 1'b1, 1'b0);
    rd(pn, 32'h0, "type 1 bus err");
    pulse(15'h0, 1'b0, 1'b1);
    rd(pn, 32'h8000, "state chg");
    apb(1'b1, cl, 32'h8000);
    $display("err done");
  endtask
  task automatic t_gate;
    apb(1'b1, en, 32'h7FFE);
    apb(1'b1, ce, 32'hFFFE);
    pulse(15'h1, 1'b0, 1'b0);
    chk("buf off", 32'h0, cpu_irq);
    pulse(15'h2, 1'b0, 1'b0);
    rd(st, 32'h12, "code gate");
    chk("buf on", 32'h1, cpu_irq);
    apb(1'b1, cl, 32'h3);
    $display("gate done");
  endtask
  task automatic t_mask;
    apb(1'b1, ml, 32'h0);
    apb(1'b1, mx, 32'h2);
    frame(1'b0, 1'b0, 29'h0, 1'b1, "std eq");
    frame(1'b0, 1'b0, 29'h1, 1'b0, "std ne");
    frame(1'b0, 1'b1, 29'h0, 1'b0, "std ide");
    frame(1'b1, 1'b1, 29'h1, 1'b1, "ext msk");
    frame(1'b1, 1'b1, 29'h40000, 1'b0, "ext ne");
    apb(1'b1, ml, 32'h28);
    frame(1'b0, 1'b1, 29'h1, 1'b1, "std msk");
    chk("new id", 32'h40000, buf14_new_id);
    apb(1'b1, ml, 32'h38);
    apb(1'b1, mx, 32'h3);
    rx_rtr <= 1'b1;
    rx_srr <= 1'b1;
    frame(1'b1, 1'b1, 29'h1, 1'b1, "ext rtr msk");
    chk("new srr", 32'h1, buf14_new_srr);
    chk("new rtr", 32'h1, buf14_new_rtr);
    $display("mask done");
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_buf;
    t_err;
    t_gate;
    t_mask;
    print_verdict;
  end
endmodule // can_basic_mask_and_interrupts_tb_top
